//--- logic/rpps_defines.vh
/*
 Constants for the shared reset/port pin block: variant codes, field
 positions and timing counts. Assumes inclusion by rpps_reset_pin_port.v only.
*/
`ifndef RPPS_DEFINES_VH
`define RPPS_DEFINES_VH

// Device variant codes
`define RPPS_VARIANT_A          1'b0
`define RPPS_VARIANT_B          1'b1

// Option byte field: 1 selects reset function on the shared pin
`define RPPS_OPT_RESET_BIT      0

// Pull-up option register 3 field for the shared pin
`define RPPS_PU3_SHARED_BIT     4

// Option read window end count; the window lasts this plus one core_clk cycles before internal reset release
`define RPPS_OPT_READ_CYCLES    4'h4

// Read sequencer states
`define RPPS_ST_HOLD            2'h0
`define RPPS_ST_READ            2'h1
`define RPPS_ST_RUN             2'h2

`endif

//--- logic/rpps_reset_pin_port.v
/*
 Pin state and function selection for the shared reset/input port pin and
 the reset-time pulls of port2_pin2 and port2_pin3.
 Assumes a core_clk at 125 MHz, an asynchronous active-low arst_n from the
 power-on clear, and a nonvolatile option byte that is stable once read.
*/
// Summary of operation
// RULE1: Variant A pulls down crystal/analog pins port2_pin2, port2_pin3 during reset.
// RULE2: Variant B pulls down port2_pin2 and port2_pin3 (ext clock) during reset.
// RULE3: Shared pin is pulled up during reset by reset function and power-on clear.
// RULE4: Option byte picks reset input or input port; port use disables external reset.
// RULE5: Option byte read after release; low shared pin before read keeps reset.
// RULE6: Variant B port mode: pull-up on shared pin when register 3 bit 4 set.
// RULE7: Reset mode: low shared pin holds internal logic in reset while low.
`timescale 1ns/10ps
`include "rpps_defines.vh"

module rpps_reset_pin_port (
    core_clk,
    arst_n,
    variantSel,
    optionByte,
    pullupOptionReg3,
    sharedPinIn,
    optReadStart,
    sysReset_n,
    optionValid,
    sharedIsPort,
    sharedPortData,
    sharedPullupOn,
    port2Pin2PulldownOn,
    port2Pin3PulldownOn
);
    input  wire       core_clk;
    input  wire       arst_n;
    input  wire       variantSel;
    input  wire [7:0] optionByte;
    input  wire [7:0] pullupOptionReg3;
    input  wire       sharedPinIn;
    output wire       optReadStart;
    output wire       sysReset_n;
    output reg        optionValid;
    output reg        sharedIsPort;
    output reg        sharedPortData;
    output wire       sharedPullupOn;
    output wire       port2Pin2PulldownOn;
    output wire       port2Pin3PulldownOn;

    reg        pinMeta;
    reg        pinSync;
    reg [1:0]  state;
    reg [1:0]  next_state;
    reg [3:0]  readCount;
    reg [3:0]  next_readCount;
    reg        resetMode;
    reg        next_resetMode;
    reg        next_sharedIsPort;
    reg        next_optionValid;
    reg        next_sharedPortData;
    wire       readDone;
    wire       latchOption;
    wire       optResetSel;
    wire       portPullReq;
    wire [1:0] pulldownVec;

    genvar     g;

    // True in the option read window
    function inRead;
        input [1:0] st;
        begin
            inRead = (st == `RPPS_ST_READ);
        end
    endfunction

    // True once the core runs
    function inRun;
        input [1:0] st;
        begin
            inRun = (st == `RPPS_ST_RUN);
        end
    endfunction

    // Two-flop synchroniser for the pin
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinMeta <= 1'b1;
            pinSync <= 1'b1;
        end else begin
            pinMeta <= sharedPinIn;
            pinSync <= pinMeta;
        end
    end

    // Read window end and option capture point
    assign readDone    = inRead(state) && (readCount == `RPPS_OPT_READ_CYCLES);
    assign latchOption = readDone && pinSync; // [RULE5]
    assign optResetSel = optionByte[`RPPS_OPT_RESET_BIT];

    // Sequencer: hold, read option byte, run
    always @* begin
        next_state = state;
        case (state)
            `RPPS_ST_HOLD: begin
                if (pinSync)
                    next_state = `RPPS_ST_READ;
            end
            `RPPS_ST_READ: begin
                if (!pinSync)
                    next_state = `RPPS_ST_HOLD; // [RULE5]
                else if (readDone)
                    next_state = `RPPS_ST_RUN;
            end
            `RPPS_ST_RUN: begin
                if (resetMode && !pinSync)
                    next_state = `RPPS_ST_HOLD; // [RULE7]
            end
            default: next_state = `RPPS_ST_HOLD;
        endcase
    end

    // Read window counter, cleared outside the window
    always @* begin
        next_readCount = 4'h0;
        if (inRead(state) && pinSync && !readDone)
            next_readCount = readCount + 4'h1;
    end

    // Option capture at end of read window
    always @* begin
        next_resetMode    = resetMode;
        next_sharedIsPort = sharedIsPort;
        next_optionValid  = optionValid;
        if (latchOption) begin
            next_resetMode    = optResetSel;  // [RULE4]
            next_sharedIsPort = ~optResetSel; // [RULE4]
            next_optionValid  = 1'b1;
        end
    end

    // Port data only in port mode
    always @* begin
        next_sharedPortData = 1'b1;
        if (sharedIsPort)
            next_sharedPortData = pinSync;
    end

    // State register
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= `RPPS_ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // Read window count register
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            readCount <= 4'h0;
        end else begin
            readCount <= next_readCount;
        end
    end

    // Option registers
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            resetMode    <= 1'b1;
            sharedIsPort <= 1'b0;
            optionValid  <= 1'b0;
        end else begin
            resetMode    <= next_resetMode;
            sharedIsPort <= next_sharedIsPort;
            optionValid  <= next_optionValid;
        end
    end

    // Port data register
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sharedPortData <= 1'b1;
        end else begin
            sharedPortData <= next_sharedPortData;
        end
    end

    assign optReadStart = inRead(state);
    // Internal reset until option read; port mode ignores the pin [RULE4]
    assign sysReset_n = inRun(state);

    // Software pull-up request in port mode [RULE6]
    assign portPullReq = (variantSel == `RPPS_VARIANT_B) &
        pullupOptionReg3[`RPPS_PU3_SHARED_BIT];
    // Pull-up through reset function until port mode chosen [RULE3] [RULE6]
    assign sharedPullupOn = sharedIsPort ? portPullReq : 1'b1;

    // Pull-downs on port2 pins while in reset
    generate
        for (g = 0; g < 2; g = g + 1) begin : gPulldown
            assign pulldownVec[g] = !sysReset_n; // [RULE1] [RULE2]
        end
    endgenerate

    assign port2Pin2PulldownOn = pulldownVec[0];
    assign port2Pin3PulldownOn = pulldownVec[1];

endmodule // rpps_reset_pin_port

//--- tb/rpps_checker.sv
/* Port checker for the shared pin block.
   Assumes binding into every rpps_reset_pin_port instance. */
`timescale 1ns/10ps
module rpps_checker (input wire core_clk, arst_n, variantSel, sharedPinIn, optReadStart,
    sysReset_n, optionValid, sharedIsPort, sharedPullupOn, port2Pin2PulldownOn,
    port2Pin3PulldownOn, input wire [7:0] optionByte, pullupOptionReg3);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence sLow; !sharedPinIn[*2]; endsequence
    AST_PD2: assert property (port2Pin2PulldownOn == !sysReset_n)
        else $error("pin2 pull");
    AST_PD3: assert property (port2Pin3PulldownOn == !sysReset_n)
        else $error("pin3 pull");
    AST_PU_RST: assert property (!sysReset_n |-> sharedPullupOn)
        else $error("reset pull-up");
    AST_PU_PORT: assert property (sharedIsPort |-> sharedPullupOn ==
        (variantSel & pullupOptionReg3[4])) else $error("port pull-up");
    AST_MODE: assert property (optionValid |-> sharedIsPort == !optionByte[0])
        else $error("mode");
    AST_PORT_RUN: assert property (sharedIsPort && sysReset_n |=> sysReset_n)
        else $error("port reset");
    AST_READ: assert property ($rose(sysReset_n) |-> $past(optReadStart) && optionValid)
        else $error("read");
    AST_PIN_RST: assert property (sysReset_n && !sharedIsPort ##0 sLow |-> ##[1:4] !sysReset_n)
        else $error("pin reset");
endmodule // rpps_checker
bind rpps_reset_pin_port rpps_checker chk (.*);

//--- tb/rpps_pin_src.sv
/* Board source of the shared pin: pull-up and a switch to ground.
   Assumes the bench commands the switch between clock edges. */
`timescale 1ns/10ps
module rpps_pin_src (input wire core_clk, input wire pullLow, output logic pin = 1'b1);
    always @(posedge core_clk) pin <= !pullLow;
endmodule // rpps_pin_src

//--- tb/tb_reset_pin_port_sharing.sv
/* Bench for the shared pin block: random options, pulls and reset gating.
   Assumes the board source model and the bound checker. */
`timescale 1ns/10ps
module tb_reset_pin_port_sharing;
    logic       coreClk = 0, arstN = 0, variantSel = 0, pullLow = 0;
    logic [7:0] optionByte = 8'h01, reg3 = 8'h00;
    wire        pin, rd, sr, ov, ip, pd, pu, p2, p3;
    integer     num_errors = 0, n_tests = 0, seed = 32'h5efae13c, i, k;
    always #4 coreClk = ~coreClk;
    rpps_pin_src src (.core_clk(coreClk), .pullLow(pullLow), .pin(pin));
    rpps_reset_pin_port dut (.core_clk(coreClk), .arst_n(arstN), .variantSel(variantSel),
        .optionByte(optionByte), .pullupOptionReg3(reg3), .sharedPinIn(pin),
        .optReadStart(rd), .sysReset_n(sr), .optionValid(ov), .sharedIsPort(ip),
        .sharedPortData(pd), .sharedPullupOn(pu), .port2Pin2PulldownOn(p2),
        .port2Pin3PulldownOn(p3));
    task chk(input logic ok);
        n_tests++;
        if (!ok) begin
            num_errors++;
            $display("Error at %0t: mismatch", $time);
        end
    endtask
    task tally_and_finish;
        $display("Checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task waitRun;
        for (k = 0; k < 20 && sr !== 1'b1; k++) @(negedge coreClk);
        chk(sr === 1'b1);
        if (sr !== 1'b1) tally_and_finish;
    endtask
    initial begin
        for (i = 0; i < 8; i++) begin
            @(negedge coreClk);
            arstN = 0;
            {optionByte, reg3} = 16'($random(seed));
            optionByte[0] = i[0];
            variantSel = i[1];
            reg3[4] = i[2];
            pullLow = i[2];
            repeat (12) @(negedge coreClk);
            chk(p2 === 1'b1 && p3 === 1'b1 && pu === 1'b1 && sr === 1'b0 &&
                rd === 1'b0 && ov === 1'b0 && ip === 1'b0 && pd === 1'b1);
            arstN = 1;
            repeat (10) @(negedge coreClk);
            if (pullLow) chk(sr === 1'b0);
            pullLow = 0;
            waitRun;
            chk(ip === ~optionByte[0] && p2 === 1'b0 && p3 === 1'b0 &&
                pu === (optionByte[0] | (variantSel & reg3[4])));
            chk(pd === 1'b1 && ov === 1'b1 && rd === 1'b0);
            pullLow = 1;
            repeat (6) @(negedge coreClk);
            chk(sr === ~optionByte[0] && (optionByte[0] || pd === 1'b0));
            pullLow = 0;
            waitRun;
        end
        tally_and_finish;
    end
endmodule // tb_reset_pin_port_sharing
